// [logic/bsr_defs.svh]
// constants for the bidirectional shift register block
// assumes a 32-bit register port with byte addresses
`ifndef BSR_DEFS_SVH
`define BSR_DEFS_SVH

`define BSR_NSTAGE 8
`define BSR_WORD_W 32
`define BSR_FIFO_DEPTH 16
`define BSR_ADDR_W 8

`define BSR_OFS_CTRL 8'h00
`define BSR_OFS_STATUS 8'h04
`define BSR_OFS_FLAGS 8'h08
`define BSR_OFS_WORD0 8'h20

`define BSR_CTRL_RELEASE_REQ 0
`define BSR_CTRL_SOFT_CLEAR 1
`define BSR_CTRL_HOLD 2

`define BSR_STAT_MODE 0
`define BSR_STAT_LOST 1
`define BSR_STAT_FULL 2
`define BSR_STAT_COUNT_LSB 8

`define BSR_RST_RELEASE_REQ 1'b1
`define BSR_RST_HOLD 1'b0

`endif

// [logic/bsr_fifo.sv]
// flip-flop fifo with valid and ready on both sides
// assumes one clock and a synchronous active-low reset
`include "bsr_defs.svh"
`default_nettype none

module bsr_fifo #(
    parameter int WIDTH = 34,
    parameter int DEPTH = `BSR_FIFO_DEPTH
) (
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic i_flush,
    input wire logic i_in_valid,
    output logic o_in_ready,
    input wire logic [WIDTH-1:0] i_in_data,
    output logic o_out_valid,
    input wire logic i_out_ready,
    output logic [WIDTH-1:0] o_out_data,
    output logic [$clog2(DEPTH):0] o_count
);
    timeunit 1ns;
    timeprecision 1ps;

    localparam int AW = $clog2(DEPTH);

    initial begin
        if (DEPTH < 2 || (1 << AW) != DEPTH || WIDTH < 1) begin
            $error("bsr_fifo: depth must be a power of two of at least 2");
        end
    end

    logic [DEPTH-1:0][WIDTH-1:0] mem_reg;
    logic [DEPTH-1:0][WIDTH-1:0] mem_next;
    logic [AW-1:0] wr_reg, wr_next, rd_reg, rd_next;
    logic [AW:0] cnt_reg, cnt_next;
    logic push, pop;

    always_comb begin
        push = i_in_valid && (cnt_reg != DEPTH[AW:0]);
        pop = i_out_ready && (cnt_reg != '0);
        mem_next = mem_reg;
        wr_next = wr_reg;
        rd_next = rd_reg;
        cnt_next = cnt_reg;
        if (i_flush) begin
            wr_next = '0;
            rd_next = '0;
            cnt_next = '0;
        end else begin
            if (push) begin
                mem_next[wr_reg] = i_in_data;
                wr_next = wr_reg + 1'b1;
            end
            if (pop) begin
                rd_next = rd_reg + 1'b1;
            end
            if (push && !pop) begin
                cnt_next = cnt_reg + 1'b1;
            end else if (pop && !push) begin
                cnt_next = cnt_reg - 1'b1;
            end
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            mem_reg <= '0;
            wr_reg <= '0;
            rd_reg <= '0;
            cnt_reg <= '0;
        end else begin
            mem_reg <= mem_next;
            wr_reg <= wr_next;
            rd_reg <= rd_next;
            cnt_reg <= cnt_next;
        end
    end

    assign o_in_ready = (cnt_reg != DEPTH[AW:0]);
    assign o_out_valid = (cnt_reg != '0);
    assign o_out_data = mem_reg[rd_reg];
    assign o_count = cnt_reg;

endmodule

`default_nettype wire

// [logic/bsr_pkg.sv]
// types of the bidirectional shift register block
// assumes bsr_defs.svh for sizes
//
// Operation
// RL1 - with release required on, shifts happen only while the release input is 1.
// RL2 - with release required off, the release input is ignored and the block runs.
// RL3 - a rising forward pulse shifts forward; in bit mode the forward flag is shifted in.
// RL4 - a rising backward pulse shifts backward; in bit mode the backward flag is shifted in.
// RL5 - while clear is 1 every flag stage and every word stage reads zero.
// RL6 - in word mode forward takes the forward word and backward the backward word, signed 32 bit.
// RL7 - bit mode and word mode exist, and bit mode is the default.
// RL8 - in bit mode the word inputs are ignored and the word outputs carry nothing.
// RL9 - eight flag stages in bit mode and eight signed 32-bit word stages in word mode.
// RL10 - nothing is retained; all stages start cleared.
// RL11 - a forward word shift puts the forward word in stage 1 and moves the rest upward.
// RL12 - a forward bit shift puts the forward flag in stage 1 and moves the rest upward.
// RL13 - a backward bit shift puts the backward flag in stage 8 and moves the rest downward.
// RL14 - a backward word shift puts the backward word in stage 8 and moves the rest downward.
// RL15 - edges are found in the system clock; clear beats shifts, forward beats backward.
`include "bsr_defs.svh"
`default_nettype none

package bsr_pkg;
    timeunit 1ns;
    timeprecision 1ps;

    typedef enum logic {
        BSR_FWD,
        BSR_BWD
    } bsr_dir_e;

    typedef logic signed [`BSR_WORD_W-1:0] bsr_word_t;

    typedef logic [`BSR_NSTAGE-1:0][`BSR_WORD_W-1:0] bsr_words_t;

    typedef struct packed {
        bsr_dir_e dir;
        logic flag;
        bsr_word_t word;
    } bsr_cmd_s;

    typedef struct packed {
        logic release_req;
        logic hold;
    } bsr_ctrl_s;

endpackage

`default_nettype wire

// [logic/bsr_top.sv]
// bidirectional shift register: edge detect, command fifo, stage chain,
// and a small register port
// assumes pulses, data, release and clear come from logic on i_clk
//
// The strobed register port and the address map were left to the implementer.
`include "bsr_defs.svh"
`default_nettype none

module bsr_top
    import bsr_pkg::*;
#(
    parameter bit DOUBLE_WORD = 1'b0,
    parameter int NSTAGE = `BSR_NSTAGE,
    parameter int FIFO_DEPTH = `BSR_FIFO_DEPTH
) (
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic i_release,
    input wire logic i_clear,
    input wire logic i_fwd_pulse,
    input wire logic i_bwd_pulse,
    input wire logic i_fwd_flag_in,
    input wire logic i_bwd_flag_in,
    input wire bsr_pkg::bsr_word_t i_fwd_word_in,
    input wire bsr_pkg::bsr_word_t i_bwd_word_in,
    input wire logic [`BSR_ADDR_W-1:0] i_addr,
    input wire logic [31:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [31:0] o_rdata,
    output logic o_pulse_ready,
    output logic [NSTAGE-1:0] o_flag_stage,
    output bsr_pkg::bsr_words_t o_word_stage
);
    timeunit 1ns;
    timeprecision 1ps;

    import bsr_pkg::*;

    localparam int CW = $clog2(FIFO_DEPTH) + 1;
    localparam int CMD_W = $bits(bsr_cmd_s);

    initial begin
        if (NSTAGE != `BSR_NSTAGE) begin
            $error("bsr_top: the stage chain is built for exactly eight stages");
        end
        if (FIFO_DEPTH < 2 || FIFO_DEPTH > 128) begin
            $error("bsr_top: fifo depth must lie between 2 and 128");
        end
        if ((1 << (CW - 1)) != FIFO_DEPTH) begin
            $error("bsr_top: fifo depth must be a power of two");
        end
    end

    // control register state

    bsr_ctrl_s ctrl_reg;
    bsr_ctrl_s ctrl_next;
    logic lost_reg;
    logic lost_next;
    logic soft_clr_reg;
    logic soft_clr_next;
    logic [31:0] rdata_reg;
    logic [31:0] rdata_next;

    // edge detection state; previous levels reset low, so a pulse
    // already high when reset lifts counts as one edge

    logic fwd_prev_reg;
    logic fwd_prev_next;
    logic bwd_prev_reg;
    logic bwd_prev_next;
    logic ready_reg;
    logic ready_next;

    // stage chain state

    logic [NSTAGE-1:0] flag_reg;
    logic [NSTAGE-1:0] flag_next;
    bsr_words_t word_reg;
    bsr_words_t word_next;

    // fifo wiring

    bsr_cmd_s in_cmd;
    bsr_cmd_s out_cmd;
    logic in_valid;
    logic in_ready;
    logic out_valid;
    logic out_ready;
    logic [CMD_W-1:0] out_raw;
    logic [CW-1:0] fifo_count;

    logic enabled;
    logic clearing;
    logic fwd_edge;
    logic bwd_edge;

    always_comb begin
        enabled = ctrl_reg.release_req ? i_release : 1'b1; // RL1 RL2
        clearing = i_clear || soft_clr_reg;
        fwd_edge = i_fwd_pulse && !fwd_prev_reg; // RL15
        bwd_edge = i_bwd_pulse && !bwd_prev_reg; // RL15
    end

    // edge detection and command forming

    always_comb begin
        fwd_prev_next = i_fwd_pulse;
        bwd_prev_next = i_bwd_pulse;
        in_cmd = '0;
        in_valid = 1'b0;
        // a tie goes forward; the backward edge of that cycle is dropped
        if (!clearing && enabled) begin // RL1 RL15
            if (fwd_edge) begin // RL3 RL15
                in_valid = 1'b1;
                in_cmd.dir = BSR_FWD;
                in_cmd.flag = DOUBLE_WORD ? 1'b0 : i_fwd_flag_in; // RL3 RL8
                in_cmd.word = DOUBLE_WORD ? i_fwd_word_in : '0; // RL6 RL8
            end else if (bwd_edge) begin // RL4
                in_valid = 1'b1;
                in_cmd.dir = BSR_BWD;
                in_cmd.flag = DOUBLE_WORD ? 1'b0 : i_bwd_flag_in; // RL4 RL8
                in_cmd.word = DOUBLE_WORD ? i_bwd_word_in : '0; // RL6 RL8
            end
        end
        ready_next = in_ready;
    end

    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            fwd_prev_reg <= 1'b0;
            bwd_prev_reg <= 1'b0;
            ready_reg <= 1'b0;
        end else begin
            fwd_prev_reg <= fwd_prev_next;
            bwd_prev_reg <= bwd_prev_next;
            ready_reg <= ready_next;
        end
    end

    // command queue between edge detection and the stage chain

    bsr_fifo #(
        .WIDTH(CMD_W),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .i_clk(i_clk),
        .i_rst_n(i_rst_n),
        .i_flush(clearing),
        .i_in_valid(in_valid),
        .o_in_ready(in_ready),
        .i_in_data(in_cmd),
        .o_out_valid(out_valid),
        .i_out_ready(out_ready),
        .o_out_data(out_raw),
        .o_count(fifo_count)
    );

    // stage chain, one command per cycle unless held or released off

    logic [NSTAGE-1:0] flag_up;
    logic [NSTAGE-1:0] flag_down;
    bsr_words_t word_up;
    bsr_words_t word_down;

    for (genvar i = 0; i < NSTAGE; i++) begin : g_stage
        if (i == 0) begin : g_first
            assign flag_up[i] = out_cmd.flag; // RL12
            assign word_up[i] = out_cmd.word; // RL11
        end else begin : g_mid_up
            assign flag_up[i] = flag_reg[i-1]; // RL12
            assign word_up[i] = word_reg[i-1]; // RL11
        end
        if (i == NSTAGE - 1) begin : g_last
            assign flag_down[i] = out_cmd.flag; // RL13
            assign word_down[i] = out_cmd.word; // RL14
        end else begin : g_mid_down
            assign flag_down[i] = flag_reg[i+1]; // RL13
            assign word_down[i] = word_reg[i+1]; // RL14
        end
    end

    always_comb begin
        out_cmd = bsr_cmd_s'(out_raw);
        // hold only stalls the queue; release low also stops new edges being queued; nothing already queued is lost
        out_ready = enabled && !ctrl_reg.hold && !clearing; // RL1
        flag_next = flag_reg;
        word_next = word_reg;
        if (clearing) begin // RL5 RL15
            flag_next = '0;
            word_next = '0;
        end else if (out_valid && out_ready) begin
            if (out_cmd.dir == BSR_FWD) begin
                if (DOUBLE_WORD) begin // RL7
                    word_next = word_up; // RL11
                end else begin
                    flag_next = flag_up; // RL12
                end
            end else begin
                if (DOUBLE_WORD) begin
                    word_next = word_down; // RL14
                end else begin
                    flag_next = flag_down; // RL13
                end
            end
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            flag_reg <= '0; // RL10
            word_reg <= '0; // RL10
        end else begin
            flag_reg <= flag_next;
            word_reg <= word_next;
        end
    end

    // register port: address decode, a read strobe per mapped register plus write strobes for control and status

    logic wr_ctrl, wr_status, rd_ctrl, rd_status, rd_flags;
    logic [NSTAGE-1:0] rd_word;
    logic [31:0] status_word;

    for (genvar k = 0; k < NSTAGE; k++) begin : g_word_sel
        assign rd_word[k] = i_rd && i_addr == `BSR_OFS_WORD0 + 8'(4 * k);
    end

    always_comb begin
        wr_ctrl = i_wr && i_addr == `BSR_OFS_CTRL;
        wr_status = i_wr && i_addr == `BSR_OFS_STATUS;
        rd_ctrl = i_rd && i_addr == `BSR_OFS_CTRL;
        rd_status = i_rd && i_addr == `BSR_OFS_STATUS;
        rd_flags = i_rd && i_addr == `BSR_OFS_FLAGS;
    end

    // status word as software sees it; count field sized by the fifo depth

    always_comb begin
        status_word = '0;
        status_word[`BSR_STAT_MODE] = DOUBLE_WORD; // RL7
        status_word[`BSR_STAT_LOST] = lost_reg;
        status_word[`BSR_STAT_FULL] = !in_ready;
        status_word[`BSR_STAT_COUNT_LSB +: CW] = fifo_count;
    end

    always_comb begin
        ctrl_next = ctrl_reg;
        soft_clr_next = 1'b0;
        lost_next = lost_reg;
        rdata_next = '0;
        if (wr_ctrl) begin
            ctrl_next.release_req = i_wdata[`BSR_CTRL_RELEASE_REQ]; // RL1 RL2
            ctrl_next.hold = i_wdata[`BSR_CTRL_HOLD];
            soft_clr_next = i_wdata[`BSR_CTRL_SOFT_CLEAR]; // RL5
        end
        if (wr_status && i_wdata[`BSR_STAT_LOST]) begin
            lost_next = 1'b0;
        end
        // an edge refused by a full fifo; setting wins over clearing
        if (in_valid && !in_ready) begin
            lost_next = 1'b1;
        end
        if (rd_ctrl) begin
            rdata_next[`BSR_CTRL_RELEASE_REQ] = ctrl_reg.release_req;
            rdata_next[`BSR_CTRL_HOLD] = ctrl_reg.hold;
        end
        if (rd_status) begin
            rdata_next = status_word;
        end
        if (rd_flags) begin
            rdata_next[NSTAGE-1:0] = flag_reg; // RL9
        end
        for (int k = 0; k < NSTAGE; k++) begin
            if (rd_word[k]) begin
                rdata_next = word_reg[k]; // RL9
            end
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            ctrl_reg.release_req <= `BSR_RST_RELEASE_REQ;
            ctrl_reg.hold <= `BSR_RST_HOLD;
            soft_clr_reg <= 1'b0;
            lost_reg <= 1'b0;
            rdata_reg <= '0;
        end else begin
            ctrl_reg <= ctrl_next;
            soft_clr_reg <= soft_clr_next;
            lost_reg <= lost_next;
            rdata_reg <= rdata_next;
        end
    end

    // every output straight from a flip-flop
    assign o_rdata = rdata_reg;
    assign o_pulse_ready = ready_reg;
    assign o_flag_stage = flag_reg; // RL9
    assign o_word_stage = word_reg; // RL9 RL8

endmodule

`default_nettype wire

// [verif/bsr_ctl_model.sv]
// model of the control logic that drives the shift pulses
// assumes go requests from the bench on the same clock
`default_nettype none

module bsr_ctl_model (
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic i_go_fwd,
    input wire logic i_go_bwd,
    output logic o_fwd_pulse,
    output logic o_bwd_pulse
);
    timeunit 1ns;
    timeprecision 1ps;
    logic fwd_next;
    logic bwd_next;
    // one-cycle pulses, always a low cycle between edges
    always_comb begin
        fwd_next = i_go_fwd && !o_fwd_pulse;
        bwd_next = i_go_bwd && !o_bwd_pulse;
    end
    always_ff @(posedge i_clk) begin
        o_fwd_pulse <= i_rst_n && fwd_next;
        o_bwd_pulse <= i_rst_n && bwd_next;
    end
endmodule

`default_nettype wire

// [verif/bsr_properties.sv]
// checker for the shift register top: clear, reset, shift shape, release gate
// assumes one clock and a bind from the bench with the top's parameters
`include "bsr_defs.svh"
`default_nettype none

module bsr_properties
    import bsr_pkg::*;
#(
    parameter bit DOUBLE_WORD = 1'b0,
    parameter int NSTAGE = `BSR_NSTAGE
) (
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic i_release,
    input wire logic i_clear,
    input wire logic [`BSR_ADDR_W-1:0] i_addr,
    input wire logic [31:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    input wire logic [31:0] o_rdata,
    input wire logic [NSTAGE-1:0] o_flag_stage,
    input wire bsr_pkg::bsr_words_t o_word_stage
);
    timeunit 1ns;
    timeprecision 1ps;
    logic rr_reg;
    logic rr_next;
    logic ctl_wr;
    assign ctl_wr = i_wr && i_addr == `BSR_OFS_CTRL;
    // mirror of the release-required control bit
    always_comb begin
        rr_next = ctl_wr ? i_wdata[0] : rr_reg;
    end
    always_ff @(posedge i_clk) begin
        rr_reg <= i_rst_n ? rr_next : 1'b1;
    end

    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (!i_rst_n);

    sequence s_frozen;
        rr_reg && !i_release && !i_clear && !ctl_wr;
    endsequence

    AST_CLEAR: assert property (i_clear |=> o_flag_stage == '0 && o_word_stage == '0)
        else $error("stages not zero after clear");
    AST_RESET: assert property (disable iff (1'b0) !i_rst_n |=> o_flag_stage == '0)
        else $error("flag stages not zero after reset");
    AST_NO_WORDS: assert property (!DOUBLE_WORD |-> o_word_stage == '0)
        else $error("word stages active in bit mode");
    AST_NO_FLAGS: assert property (DOUBLE_WORD |-> o_flag_stage == '0)
        else $error("flag stages active in word mode");
    AST_FLAG_SHIFT: assert property ($changed(o_flag_stage) |-> o_flag_stage == '0
        || o_flag_stage[7:1] == $past(o_flag_stage[6:0])
        || o_flag_stage[6:0] == $past(o_flag_stage[7:1]))
        else $error("flag stages moved other than by one");
    AST_WORD_SHIFT: assert property ($changed(o_word_stage) |-> o_word_stage == '0
        || o_word_stage[7:1] == $past(o_word_stage[6:0])
        || o_word_stage[6:0] == $past(o_word_stage[7:1]))
        else $error("word stages moved other than by one");
    AST_FROZEN: assert property (s_frozen ##1 s_frozen |=> $stable(o_flag_stage)
        && $stable(o_word_stage))
        else $error("stages moved without release");
    AST_RDATA_IDLE: assert property (!$past(i_rd) |-> o_rdata == '0)
        else $error("read data outside read answer");
endmodule

`default_nettype wire

// [verif/bsr_top_tb.sv]
// bench: bit and word instances share stimulus, row table then hand tests
// assumes the pulse model and the checker bound to bsr_top
`include "bsr_defs.svh"
`default_nettype none

module bsr_top_tb
    import bsr_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct packed {
        logic [1:0] op;
        logic ff;
        logic bf;
        bsr_word_t fw;
        bsr_word_t bw;
        logic [7:0] exp;
    } bsr_row_s;
    // op: 1 forward, 2 backward, 3 both, 0 clear
    bsr_row_s rows [7] = '{
        '{2'h1, 1'b1, 1'b0, 32'h80000000, 32'h0, 8'h01},
        '{2'h1, 1'b0, 1'b0, 32'h7FFFFFFF, 32'h0, 8'h02},
        '{2'h1, 1'b1, 1'b0, 32'hFFFFFFFF, 32'h0, 8'h05},
        '{2'h2, 1'b0, 1'b1, 32'h0, 32'h0000000A, 8'h82},
        '{2'h3, 1'b0, 1'b1, 32'h00000034, 32'h12345678, 8'h04},
        '{2'h0, 1'b0, 1'b0, 32'h0, 32'h0, 8'h00},
        '{2'h1, 1'b1, 1'b0, 32'h00000005, 32'h0, 8'h01}};
    logic clk;
    logic rst_n = 1'b0, rel = 1'b1, clr = 1'b0, go_f = 1'b0, go_b = 1'b0;
    logic ff = 1'b0, bf = 1'b0, wr = 1'b0, rd = 1'b0, fp, bp, prdy0, prdy1;
    bsr_word_t fw = '0, bw = '0;
    logic [7:0] addr = '0;
    logic [31:0] wdata = '0, rdata0, rdata1, d0, d1;
    logic [7:0] flags0, flags1;
    bsr_words_t words0, words1, mw = '0;
    int checks = 0, n_mismatch = 0;

    bsr_ctl_model i_bsr_ctl_model (.i_clk(clk), .i_rst_n(rst_n), .i_go_fwd(go_f),
        .i_go_bwd(go_b), .o_fwd_pulse(fp), .o_bwd_pulse(bp));
    bsr_top i_bsr_top (.i_clk(clk), .i_rst_n(rst_n), .i_release(rel), .i_clear(clr),
        .i_fwd_pulse(fp), .i_bwd_pulse(bp), .i_fwd_flag_in(ff), .i_bwd_flag_in(bf),
        .i_fwd_word_in(fw), .i_bwd_word_in(bw), .i_addr(addr), .i_wdata(wdata),
        .i_wr(wr), .i_rd(rd), .o_rdata(rdata0), .o_pulse_ready(prdy0),
        .o_flag_stage(flags0), .o_word_stage(words0));
    bsr_top #(.DOUBLE_WORD(1'b1)) i_bsr_top_dw (.i_clk(clk), .i_rst_n(rst_n),
        .i_release(rel), .i_clear(clr), .i_fwd_pulse(fp), .i_bwd_pulse(bp),
        .i_fwd_flag_in(ff), .i_bwd_flag_in(bf), .i_fwd_word_in(fw), .i_bwd_word_in(bw),
        .i_addr(addr), .i_wdata(wdata), .i_wr(wr), .i_rd(rd), .o_rdata(rdata1),
        .o_pulse_ready(prdy1), .o_flag_stage(flags1), .o_word_stage(words1));

    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    task automatic print_verdict;
        $display("checks %0d n_mismatch %0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    task automatic chk(input logic [255:0] got, input logic [255:0] exp);
        checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("mismatch at %0t: got %0h exp %0h", $time, got, exp);
        end
    endtask

    task automatic shot(input logic [1:0] op, input logic f, input logic b,
        input bsr_word_t wf, input bsr_word_t wb);
        @(posedge clk);
        ff <= f;
        bf <= b;
        fw <= wf;
        bw <= wb;
        go_f <= op[0];
        go_b <= op[1];
        clr <= op == 2'h0;
        @(posedge clk);
        go_f <= 1'b0;
        go_b <= 1'b0;
        clr <= 1'b0;
        repeat (4) @(posedge clk);
        #1;
    endtask

    task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask

    task automatic rd_reg(input logic [7:0] a);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        d0 = rdata0;
        d1 = rdata1;
    endtask

    initial begin
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        foreach (rows[i]) begin
            shot(rows[i].op, rows[i].ff, rows[i].bf, rows[i].fw, rows[i].bw);
            if (rows[i].op[0]) mw = {mw[6:0], rows[i].fw};
            else if (rows[i].op[1]) mw = {rows[i].bw, mw[7:1]};
            else mw = '0;
            chk(flags0, rows[i].exp);
            chk(words1, mw);
            chk(words0, '0);
            chk(flags1, '0);
        end
        // second reset in mid-run
        @(posedge clk);
        rst_n <= 1'b0;
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        #1;
        chk(flags0, '0);
        chk(words1, '0);
        rd_reg(`BSR_OFS_CTRL);
        chk(d0[0], 1'b1);
        rd_reg(`BSR_OFS_STATUS);
        chk({d0[0], d1[0]}, 2'b01);
        rd_reg(8'h44);
        chk(d0, '0);
        @(posedge clk);
        rel <= 1'b0;
        shot(2'h1, 1'b1, 1'b0, 32'h5, 32'h0);
        chk(flags0, '0);
        wr_reg(`BSR_OFS_CTRL, 32'h0);
        shot(2'h1, 1'b1, 1'b0, 32'h5, 32'h0);
        chk(flags0, 8'h01);
        wr_reg(`BSR_OFS_CTRL, 32'h2);
        repeat (2) @(posedge clk);
        #1;
        chk(flags0, '0);
        // hold the drain and overfill the queue
        wr_reg(`BSR_OFS_CTRL, 32'h4);
        repeat (17) shot(2'h1, 1'b1, 1'b0, 32'h11, 32'h0);
        chk({prdy0, prdy1, flags0}, 10'h000);
        rd_reg(`BSR_OFS_STATUS);
        chk(d0[12:0], 13'h1006);
        wr_reg(`BSR_OFS_CTRL, 32'h0);
        repeat (20) @(posedge clk);
        #1;
        chk(flags0, 8'hFF);
        chk(words1, {8{32'h11}});
        rd_reg(`BSR_OFS_FLAGS);
        chk({d0[7:0], d1[7:0]}, 16'hFF00);
        rd_reg(`BSR_OFS_WORD0 + 8'h1C);
        chk({d0, d1}, {32'h0, 32'h11});
        wr_reg(`BSR_OFS_STATUS, 32'h2);
        rd_reg(`BSR_OFS_STATUS);
        chk({prdy0, prdy1, d0[12:0]}, 15'h6000);
        print_verdict();
    end

    initial begin
        repeat (20000) @(posedge clk);
        n_mismatch++;
        print_verdict();
    end
endmodule

bind bsr_top bsr_properties #(.DOUBLE_WORD(DOUBLE_WORD), .NSTAGE(NSTAGE)) i_bsr_properties (
    .i_clk(i_clk), .i_rst_n(i_rst_n), .i_release(i_release), .i_clear(i_clear),
    .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
    .o_flag_stage(o_flag_stage), .o_word_stage(o_word_stage));

`default_nettype wire
